//--- design/sca_shift_counter.sv
// Shift counters with automatic refill of the output shift register and
// automatic drain of the input shift register, plus a Wishbone register file.
// Assumes the executor holds each operation until op_done_o and that the
// TX FIFO read port and RX FIFO write port sit outside this block.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`default_nettype none

module sca_shift_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sca_pkg::sca_wb_req_s wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire sca_pkg::sca_op_s op_i,
    output logic op_done_o,
    output logic op_stall_o,
    output logic emit_valid_o,
    output logic [31:0] emit_data_o,
    output logic [31:0] copy_data_o,
    input wire logic tx_valid_i,
    input wire logic [31:0] tx_data_i,
    output logic tx_pop_o,
    input wire logic rx_ready_i,
    output logic rx_push_o,
    output logic [31:0] rx_data_o,
    output logic side_valid_o,
    output logic [4:0] side_o
);
    import sca_pkg::*;

    sca_state_s s_reg;
    sca_state_s s_next;
    logic [5:0] pull_thresh;
    logic [5:0] push_thresh;

    // Saturating counter addition
    function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
        logic [6:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return (sum > {1'b0, SCA_CNT_SAT}) ? SCA_CNT_SAT : sum[5:0];
    endfunction

    // Mask of the low n bits of a word
    function automatic logic [31:0] low_mask(input logic [5:0] n);
        logic [31:0] m;
        m = 32'hFFFF_FFFF;
        if (n < SCA_WORD_BITS) begin
            m = ~(32'hFFFF_FFFF << n);
        end
        return m;
    endfunction

    // Byte lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    sca_thresh_decode u_thresh (
        .pull_field_i(s_reg.cfg[SCA_CFG_PULL_LSB +: 5]),
        .push_field_i(s_reg.cfg[SCA_CFG_PUSH_LSB +: 5]),
        .pull_thresh_o(pull_thresh),
        .push_thresh_o(push_thresh)
    );

    // Next state of the whole block
    always_comb begin
        logic refill_en;
        logic drain_en;
        logic op_go;
        logic tx_avail;
        logic rx_room;
        logic restart;
        logic loaded;
        logic stall;
        logic [5:0] n;
        logic [5:0] cnt;
        logic [31:0] isr_shift;
        s_next = s_reg;
        refill_en = s_reg.cfg[SCA_CFG_REFILL_BIT];
        drain_en = s_reg.cfg[SCA_CFG_DRAIN_BIT];
        // An op seen done last cycle is the same op; it is not run twice
        op_go = op_i.valid && !s_reg.done;
        // A word popped last cycle is still on the FIFO output
        tx_avail = tx_valid_i && !s_reg.tx_pop;
        rx_room = rx_ready_i && !s_reg.rx_push;
        restart = 1'b0;
        loaded = 1'b0;
        stall = 1'b0;
        n = op_i.bit_count;
        cnt = 6'h00;
        isr_shift = 32'h0000_0000;
        s_next.tx_pop = 1'b0;
        s_next.rx_push = 1'b0;
        s_next.done = 1'b0;
        s_next.emit_valid = 1'b0;
        s_next.side_valid = 1'b0;
        s_next.wb_ack = 1'b0;

        // Wishbone slave, one wait state, ack dropped after one cycle
        if (wb_i.cyc && wb_i.stb && !s_reg.wb_ack) begin
            s_next.wb_ack = 1'b1;
            s_next.wb_dat = 32'h0000_0000;
            if (wb_i.we) begin
                if (wb_i.adr == SCA_REG_CONFIG) begin
                    s_next.cfg = lane_merge(s_reg.cfg, wb_i.dat, wb_i.sel) & SCA_CFG_MASK;
                end else if (wb_i.adr == SCA_REG_CONTROL) begin
                    restart = wb_i.sel[0] && wb_i.dat[SCA_CTRL_RESTART_BIT];
                end
            end else begin
                if (wb_i.adr == SCA_REG_CONFIG) begin
                    s_next.wb_dat = s_reg.cfg;
                end else if (wb_i.adr == SCA_REG_STATUS) begin
                    s_next.wb_dat[SCA_STAT_OUT_LSB +: 6] = s_reg.out_cnt;
                    s_next.wb_dat[SCA_STAT_IN_LSB +: 6] = s_reg.in_cnt;
                    s_next.wb_dat[SCA_STAT_STALL_BIT] = s_reg.stall;
                end else if (wb_i.adr == SCA_REG_OSR) begin
                    s_next.wb_dat = s_reg.osr;
                end else if (wb_i.adr == SCA_REG_ISR) begin
                    s_next.wb_dat = s_reg.isr;
                end
            end
        end

        // Side-set follows every cycle the op is presented, stalled or not
        if (op_go && op_i.side_en) begin
            s_next.side = op_i.side;
            s_next.side_valid = 1'b1;
        end

        // Output shift register path
        if (op_go && op_i.kind == SCA_OP_EMIT) begin
            if (refill_en && s_reg.out_cnt >= pull_thresh) begin
                // Empty register: refill now, shift next time
                stall = 1'b1;
                if (tx_avail) begin
                    s_next.osr = tx_data_i;
                    s_next.out_cnt = 6'h00;
                    s_next.tx_pop = 1'b1;
                end
            end else begin
                s_next.emit_valid = !op_i.emit_to_rx;
                s_next.emit_data = s_reg.osr & low_mask(n);
                s_next.osr = (n >= SCA_WORD_BITS) ? 32'h0000_0000 : (s_reg.osr >> n);
                cnt = sat_add(s_reg.out_cnt, n);
                s_next.out_cnt = cnt;
                if (refill_en && cnt >= pull_thresh && tx_avail) begin
                    // Refill alongside the last bits going out
                    s_next.osr = tx_data_i;
                    s_next.out_cnt = 6'h00;
                    s_next.tx_pop = 1'b1;
                end
            end
        end else begin
            cnt = s_reg.out_cnt;
            if (op_go && op_i.kind == SCA_OP_COPY_TO_TX) begin
                s_next.osr = op_i.data;
                cnt = 6'h00;
            end else if (op_go && op_i.kind == SCA_OP_COPY_FROM_TX) begin
                s_next.copy_data = s_reg.osr;
            end else if (op_go && (op_i.kind == SCA_OP_FETCH ||
                                   op_i.kind == SCA_OP_FETCH_COND)) begin
                if (op_i.kind == SCA_OP_FETCH_COND && s_reg.out_cnt < pull_thresh) begin
                    loaded = 1'b0;
                end else if (refill_en && s_reg.out_cnt == 6'h00) begin
                    loaded = 1'b0;
                end else if (tx_avail) begin
                    s_next.osr = tx_data_i;
                    s_next.tx_pop = 1'b1;
                    cnt = 6'h00;
                    loaded = 1'b1;
                end else begin
                    stall = 1'b1;
                end
            end
            s_next.out_cnt = cnt;
            if (refill_en && !loaded && cnt >= pull_thresh && tx_avail) begin
                s_next.osr = tx_data_i;
                s_next.out_cnt = 6'h00;
                s_next.tx_pop = 1'b1;
            end
        end

        // Input shift register path
        if (op_go && op_i.kind == SCA_OP_CAPTURE) begin
            isr_shift = (n >= SCA_WORD_BITS) ? op_i.data :
                        ((s_reg.isr << n) | (op_i.data & low_mask(n)));
            cnt = sat_add(s_reg.in_cnt, n);
            if (drain_en && cnt >= push_thresh) begin
                if (!rx_room) begin
                    stall = 1'b1;
                end else begin
                    s_next.rx_data = isr_shift;
                    s_next.rx_push = 1'b1;
                    s_next.isr = 32'h0000_0000;
                    s_next.in_cnt = 6'h00;
                end
            end else begin
                s_next.isr = isr_shift;
                s_next.in_cnt = cnt;
            end
        end else if (op_go && op_i.kind == SCA_OP_STORE) begin
            if (rx_room) begin
                s_next.rx_data = s_reg.isr;
                s_next.rx_push = 1'b1;
                s_next.isr = 32'h0000_0000;
                s_next.in_cnt = 6'h00;
            end else begin
                stall = 1'b1;
            end
        end else if (op_go && op_i.kind == SCA_OP_COPY_TO_RX) begin
            s_next.isr = op_i.data;
            s_next.in_cnt = 6'h00;
        end else if (op_go && op_i.kind == SCA_OP_EMIT && op_i.emit_to_rx && !stall) begin
            s_next.isr = s_reg.osr & low_mask(n);
            s_next.in_cnt = n;
        end

        // Completion of the presented op
        s_next.stall = op_go && stall;
        s_next.done = op_go && !stall;

        // Restart wins over the counters, shift registers, FIFO strobes and op answer of this cycle; side-set and copy data are kept
        if (restart) begin
            s_next.out_cnt = SCA_OUT_CNT_RESET;
            s_next.in_cnt = SCA_IN_CNT_RESET;
            s_next.osr = 32'h0000_0000;
            s_next.isr = 32'h0000_0000;
            s_next.tx_pop = 1'b0;
            s_next.rx_push = 1'b0;
            s_next.done = 1'b0;
            s_next.stall = 1'b0;
            s_next.emit_valid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= SCA_STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign wb_ack_o = s_reg.wb_ack;
    assign wb_dat_o = s_reg.wb_dat;
    assign op_done_o = s_reg.done;
    assign op_stall_o = s_reg.stall;
    assign emit_valid_o = s_reg.emit_valid;
    assign emit_data_o = s_reg.emit_data;
    assign copy_data_o = s_reg.copy_data;
    assign tx_pop_o = s_reg.tx_pop;
    assign rx_push_o = s_reg.rx_push;
    assign rx_data_o = s_reg.rx_data;
    assign side_valid_o = s_reg.side_valid;
    assign side_o = s_reg.side;

endmodule

`default_nettype wire

//--- design/sca_thresh_decode.sv
// Threshold field decoder for the refill and drain comparisons.
// Assumes the fields come straight from the configuration register.
`default_nettype none

module sca_thresh_decode (
    input wire logic [4:0] pull_field_i,
    input wire logic [4:0] push_field_i,
    output logic [5:0] pull_thresh_o,
    output logic [5:0] push_thresh_o
);
    import sca_pkg::*;

    // Field zero means a whole word, other values are used as they are
    always_comb begin
        pull_thresh_o = (pull_field_i == 5'h00) ? SCA_THRESH_ZERO : {1'b0, pull_field_i};
        push_thresh_o = (push_field_i == 5'h00) ? SCA_THRESH_ZERO : {1'b0, push_field_i};
    end

endmodule

`default_nettype wire

//--- inc/sca_pkg.sv
// Shared constants and types for the shift counter and auto refill block.
// Assumes one system clock; the executor and the FIFOs sit outside.
`default_nettype none

package sca_pkg;

    // Counter values
    localparam logic [5:0] SCA_IN_CNT_RESET = 6'h00;  // Nothing shifted in
    localparam logic [5:0] SCA_OUT_CNT_RESET = 6'h20; // Nothing left to shift out
    localparam logic [5:0] SCA_CNT_SAT = 6'h20;       // Saturation value
    localparam logic [5:0] SCA_THRESH_ZERO = 6'h20;   // Threshold meant by field 0
    localparam logic [5:0] SCA_WORD_BITS = 6'h20;

    // Register byte offsets
    localparam logic [7:0] SCA_REG_CONFIG = 8'h00;
    localparam logic [7:0] SCA_REG_CONTROL = 8'h04;
    localparam logic [7:0] SCA_REG_STATUS = 8'h08;
    localparam logic [7:0] SCA_REG_OSR = 8'h0C;
    localparam logic [7:0] SCA_REG_ISR = 8'h10;

    // Field positions
    localparam int unsigned SCA_CFG_REFILL_BIT = 0;
    localparam int unsigned SCA_CFG_DRAIN_BIT = 1;
    localparam int unsigned SCA_CFG_PULL_LSB = 8;
    localparam int unsigned SCA_CFG_PUSH_LSB = 16;
    localparam int unsigned SCA_CTRL_RESTART_BIT = 0;
    localparam int unsigned SCA_STAT_OUT_LSB = 0;
    localparam int unsigned SCA_STAT_IN_LSB = 8;
    localparam int unsigned SCA_STAT_STALL_BIT = 16;
    localparam logic [31:0] SCA_CFG_MASK = 32'h001F_1F03;
    localparam logic [31:0] SCA_CFG_RESET = 32'h0000_0000;

    // Operations presented by the executor
    typedef enum logic [3:0] {
        SCA_OP_NONE = 4'h0,
        SCA_OP_EMIT = 4'h1,
        SCA_OP_CAPTURE = 4'h2,
        SCA_OP_FETCH = 4'h3,
        SCA_OP_FETCH_COND = 4'h4,
        SCA_OP_STORE = 4'h5,
        SCA_OP_COPY_TO_TX = 4'h6,
        SCA_OP_COPY_TO_RX = 4'h7,
        SCA_OP_COPY_FROM_TX = 4'h8
    } sca_op_e;

    typedef struct packed {
        logic valid;
        sca_op_e kind;
        logic [5:0] bit_count;
        logic emit_to_rx;
        logic [31:0] data;
        logic side_en;
        logic [4:0] side;
    } sca_op_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } sca_wb_req_s;

    // Whole state of the top module
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] osr;
        logic [31:0] isr;
        logic [5:0] out_cnt;
        logic [5:0] in_cnt;
        logic tx_pop;
        logic rx_push;
        logic [31:0] rx_data;
        logic done;
        logic stall;
        logic emit_valid;
        logic [31:0] emit_data;
        logic [31:0] copy_data;
        logic side_valid;
        logic [4:0] side;
        logic wb_ack;
        logic [31:0] wb_dat;
    } sca_state_s;

    localparam sca_state_s SCA_STATE_RESET = '{
        cfg: SCA_CFG_RESET,
        osr: 32'h0000_0000,
        isr: 32'h0000_0000,
        out_cnt: SCA_OUT_CNT_RESET,
        in_cnt: SCA_IN_CNT_RESET,
        tx_pop: 1'b0,
        rx_push: 1'b0,
        rx_data: 32'h0000_0000,
        done: 1'b0,
        stall: 1'b0,
        emit_valid: 1'b0,
        emit_data: 32'h0000_0000,
        copy_data: 32'h0000_0000,
        side_valid: 1'b0,
        side: 5'h00,
        wb_ack: 1'b0,
        wb_dat: 32'h0000_0000
    };

endpackage

`default_nettype wire

//--- testbench/sca_checker_sva.sv
// Concurrent checks on the shift counter ports: op answers, FIFO strobes, side-set.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module sca_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire sca_pkg::sca_wb_req_s wb_i,
    input wire logic wb_ack_o,
    input wire sca_pkg::sca_op_s op_i,
    input wire logic op_done_o,
    input wire logic op_stall_o,
    input wire logic emit_valid_o,
    input wire logic [31:0] emit_data_o,
    input wire logic tx_valid_i,
    input wire logic tx_pop_o,
    input wire logic rx_ready_i,
    input wire logic rx_push_o,
    input wire logic side_valid_o,
    input wire logic [4:0] side_o
);
    import sca_pkg::*;
    logic quiet;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // No bus write pending, so no restart can cancel an op
    assign quiet = !(wb_i.cyc && wb_i.we);

    a_ack_pulse: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle pulse");
    a_op_answer: assert property (op_i.valid && !op_done_o && quiet |=> op_done_o != op_stall_o)
        else $error("op attempt without exactly one of done or stall");
    a_side_each: assert property (op_i.valid && op_i.side_en && !op_done_o && quiet
        |=> side_valid_o && side_o == $past(op_i.side))
        else $error("side value not applied on attempt");
    a_emit_width: assert property (emit_valid_o |-> (emit_data_o >> $past(op_i.bit_count)) == 32'h0)
        else $error("emit data wider than bit count");
    a_stall_quiet: assert property (op_stall_o |-> !emit_valid_o && !rx_push_o)
        else $error("stalled op shifted or pushed");
    a_pop_valid: assert property (tx_pop_o |-> $past(tx_valid_i))
        else $error("pop from empty transmit queue");
    a_pop_gap: assert property (tx_pop_o |=> !tx_pop_o)
        else $error("pop in back to back cycles");
    a_push_room: assert property (rx_push_o |-> $past(rx_ready_i))
        else $error("push into full receive queue");
    a_push_gap: assert property (rx_push_o |=> !rx_push_o)
        else $error("push in back to back cycles");

    // Main scenarios reached
    c_stall_done: cover property (op_stall_o ##1 op_done_o);
    c_pop_done: cover property (op_done_o && tx_pop_o);
    c_push: cover property (rx_push_o);
endmodule

bind sca_shift_counter sca_checker sca_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_ack_o(wb_ack_o), .op_i(op_i), .op_done_o(op_done_o), .op_stall_o(op_stall_o),
    .emit_valid_o(emit_valid_o), .emit_data_o(emit_data_o), .tx_valid_i(tx_valid_i),
    .tx_pop_o(tx_pop_o), .rx_ready_i(rx_ready_i), .rx_push_o(rx_push_o),
    .side_valid_o(side_valid_o), .side_o(side_o));

`default_nettype wire

//--- testbench/sca_sys_model.sv
// System side model: show-ahead transmit queue and receive sink with a block input.
// Assumes pop and push strobes are single-cycle pulses from the block.
`default_nettype none

module sca_sys_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pop_i,
    input wire logic push_i,
    input wire logic [31:0] push_data_i,
    input wire logic block_i,
    output logic tx_valid_o,
    output logic [31:0] tx_data_o,
    output logic rx_ready_o
);
    logic [31:0] txq[$];
    logic [31:0] rxq[$];
    logic [31:0] last;

    // Known levels before the first edge
    initial begin
        tx_valid_o = 1'h0;
        tx_data_o = 32'h0;
        rx_ready_o = 1'h0;
        last = 32'h0;
    end

    // Queue a word for the block
    task automatic add_tx(input logic [31:0] w);
        txq.push_back(w);
    endtask

    // Consume, collect, and present the next head; an empty queue shows stale-inverted data
    always @(posedge clk_i) begin
        if (pop_i && txq.size() != 0) begin
            last = txq.pop_front();
        end
        if (push_i) begin
            rxq.push_back(push_data_i);
        end
        tx_valid_o <= !rst_i && txq.size() != 0;
        tx_data_o <= (txq.size() != 0) ? txq[0] : ~last;
        rx_ready_o <= !rst_i && !block_i;
    end
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the shift counter block with the system side model.
// Assumes the package constants and the hand-over timing of the op and bus ports.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sca_pkg::*;
    typedef struct packed {
        logic [31:0] cfg;
        sca_op_e kind;
        logic [5:0] n;
        logic to_rx;
        logic pre;
        logic [5:0] eo;
        logic [5:0] ei;
    } sca_row_s;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    sca_wb_req_s wb = '0;
    sca_op_s op = '0;
    logic wb_ack, op_done, op_stall, emit_valid, tx_valid, tx_pop, rx_ready, rx_push;
    logic side_valid, rx_block = 1'h0;
    logic [31:0] wb_dat, emit_data, copy_data, tx_data, rx_data, rd, ed;
    logic [4:0] side;
    int checks = 0;
    int mismatches = 0;
    int stalls = 0;
    int cycles = 0;
    sca_row_s rows[20] = '{
        '{32'h0, SCA_OP_FETCH, 6'h00, 1'h0, 1'h1, 6'h00, 6'h00},
        '{32'h0, SCA_OP_EMIT, 6'h08, 1'h0, 1'h0, 6'h08, 6'h00},
        '{32'h0, SCA_OP_EMIT, 6'h1E, 1'h0, 1'h0, 6'h20, 6'h00},
        '{32'h0, SCA_OP_CAPTURE, 6'h14, 1'h0, 1'h0, 6'h20, 6'h14},
        '{32'h0, SCA_OP_CAPTURE, 6'h14, 1'h0, 1'h0, 6'h20, 6'h20},
        '{32'h0, SCA_OP_STORE, 6'h00, 1'h0, 1'h0, 6'h20, 6'h00},
        '{32'h0, SCA_OP_EMIT, 6'h05, 1'h1, 1'h0, 6'h20, 6'h05},
        '{32'h0, SCA_OP_COPY_TO_TX, 6'h00, 1'h0, 1'h0, 6'h00, 6'h05},
        '{32'h0, SCA_OP_COPY_TO_RX, 6'h00, 1'h0, 1'h0, 6'h00, 6'h00},
        '{32'h0, SCA_OP_EMIT, 6'h04, 1'h0, 1'h0, 6'h04, 6'h00},
        '{32'h800, SCA_OP_FETCH_COND, 6'h00, 1'h0, 1'h0, 6'h04, 6'h00},
        '{32'h800, SCA_OP_EMIT, 6'h04, 1'h0, 1'h0, 6'h08, 6'h00},
        '{32'h800, SCA_OP_FETCH_COND, 6'h00, 1'h0, 1'h1, 6'h00, 6'h00},
        '{32'h80002, SCA_OP_CAPTURE, 6'h08, 1'h0, 1'h0, 6'h00, 6'h00},
        '{32'h2, SCA_OP_CAPTURE, 6'h10, 1'h0, 1'h0, 6'h00, 6'h10},
        '{32'h2, SCA_OP_CAPTURE, 6'h10, 1'h0, 1'h0, 6'h00, 6'h00},
        '{32'h2, SCA_OP_STORE, 6'h00, 1'h0, 1'h0, 6'h00, 6'h00},
        '{32'h1, SCA_OP_EMIT, 6'h08, 1'h0, 1'h0, 6'h08, 6'h00},
        '{32'h1, SCA_OP_FETCH, 6'h00, 1'h0, 1'h1, 6'h00, 6'h00},
        '{32'h1, SCA_OP_FETCH, 6'h00, 1'h0, 1'h0, 6'h00, 6'h00}};

    sca_shift_counter sca_shift_counter_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
        .wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .op_i(op), .op_done_o(op_done),
        .op_stall_o(op_stall), .emit_valid_o(emit_valid), .emit_data_o(emit_data),
        .copy_data_o(copy_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_pop_o(tx_pop),
        .rx_ready_i(rx_ready), .rx_push_o(rx_push), .rx_data_o(rx_data),
        .side_valid_o(side_valid), .side_o(side));
    sca_sys_model sca_sys_model_inst (.clk_i(clk_i), .rst_i(rst_i), .pop_i(tx_pop),
        .push_i(rx_push), .push_data_i(rx_data), .block_i(rx_block), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .rx_ready_o(rx_ready));

    // 250 MHz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One classic bus cycle; data taken at the ack edge
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb <= '{1'h1, 1'h1, we, 4'hF, adr, dat};
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'h1);
        rd = wb_dat;
        wb <= '0;
        @(posedge clk_i);
    endtask

    // Present an op until done, counting stalls
    task automatic run_op(input sca_op_e k, input logic [5:0] n, input logic to_rx,
        input logic [31:0] d, input logic [4:0] s);
        op <= '{1'h1, k, n, to_rx, d, 1'h1, s};
        stalls = 0;
        do begin
            @(posedge clk_i);
            if (op_stall === 1'h1) stalls++;
        end while (op_done !== 1'h1);
        ed = emit_data;
        op <= '0;
        @(posedge clk_i);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb_io(1'h0, SCA_REG_STATUS, 32'h0);
        chk("reset_counts", rd & 32'h3F3F, 32'h0020);
        wb_io(1'h0, SCA_REG_CONFIG, 32'h0);
        chk("cfg_reset", rd, SCA_CFG_RESET);
        wb_io(1'h1, SCA_REG_CONFIG, 32'hFFFF_FFFF);
        wb_io(1'h0, SCA_REG_CONFIG, 32'h0);
        chk("cfg_mask", rd, SCA_CFG_MASK);
        wb_io(1'h0, 8'h1C, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("register test done");
        for (int r = 0; r < 20; r++) begin
            wb_io(1'h1, SCA_REG_CONFIG, rows[r].cfg);
            if (rows[r].pre) begin
                sca_sys_model_inst.add_tx(32'h1000_0000 + r);
                repeat (3) @(posedge clk_i);
            end
            run_op(rows[r].kind, rows[r].n, rows[r].to_rx, 32'h0000_00C3, 5'h03);
            wb_io(1'h0, SCA_REG_STATUS, 32'h0);
            chk("out_count", {26'h0, rd[5:0]}, {26'h0, rows[r].eo});
            chk("in_count", {26'h0, rd[13:8]}, {26'h0, rows[r].ei});
            chk("row_stalls", 32'(stalls), 32'h0);
            $display("row %0d done", r);
        end
        // Refill stall on an empty queue, then shift from the loaded word
        wb_io(1'h1, SCA_REG_CONTROL, 32'h1);
        wb_io(1'h0, SCA_REG_STATUS, 32'h0);
        chk("restart_counts", rd & 32'h3F3F, 32'h0020);
        wb_io(1'h1, SCA_REG_CONFIG, 32'h0000_0801);
        fork
            run_op(SCA_OP_EMIT, 6'h08, 1'h0, 32'h0, 5'h15);
            begin
                repeat (4) @(posedge clk_i);
                sca_sys_model_inst.add_tx(32'h8765_4321);
                sca_sys_model_inst.add_tx(32'h0000_00A5);
            end
        join
        chk("emit_stalled", 32'(stalls > 1), 32'h1);
        chk("emit_first", ed, 32'h21);
        chk("side_kept", {27'h0, side}, 32'h15);
        run_op(SCA_OP_EMIT, 6'h04, 1'h0, 32'h0, 5'h0A);
        chk("emit_refilled", ed, 32'h5);
        // Copy out of the output register returns what is left after the shift
        run_op(SCA_OP_COPY_FROM_TX, 6'h00, 1'h0, 32'h0, 5'h0A);
        chk("copy_out", copy_data, 32'h0000_000A);
        wb_io(1'h0, SCA_REG_OSR, 32'h0);
        chk("osr_read", rd, 32'h0000_000A);
        $display("refill test done");
        // Drain into a full receive queue stalls until room appears
        wb_io(1'h1, SCA_REG_CONFIG, 32'h0008_0002);
        rx_block <= 1'h1;
        repeat (3) @(posedge clk_i);
        fork
            run_op(SCA_OP_CAPTURE, 6'h08, 1'h0, 32'h0000_005A, 5'h0A);
            begin
                repeat (5) @(posedge clk_i);
                wb_io(1'h0, SCA_REG_STATUS, 32'h0);
                rx_block <= 1'h0;
            end
        join
        chk("drain_stalled", 32'(stalls > 0), 32'h1);
        chk("stall_flag", {31'h0, rd[SCA_STAT_STALL_BIT]}, 32'h1);
        chk("drain_word", sca_sys_model_inst.rxq[$], 32'h0000_005A);
        wb_io(1'h0, SCA_REG_STATUS, 32'h0);
        chk("drain_count", {26'h0, rd[13:8]}, 32'h0);
        // Below the push threshold the captured bits stay in the input register
        run_op(SCA_OP_CAPTURE, 6'h04, 1'h0, 32'h0000_0005, 5'h0A);
        wb_io(1'h0, SCA_REG_ISR, 32'h0);
        chk("isr_read", rd, 32'h0000_0005);
        $display("drain test done");
        // Mid-run reset returns counters and configuration to their reset values
        rst_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wb_io(1'h0, SCA_REG_STATUS, 32'h0);
        chk("reset_again", rd & 32'h3F3F, 32'h0020);
        wb_io(1'h0, SCA_REG_CONFIG, 32'h0);
        chk("cfg_again", rd, SCA_CFG_RESET);
        $display("reset test done");
        test_done();
    end
endmodule

`default_nettype wire
